//--- inc/scsd_defs.svh
`ifndef SCSD_DEFS_SVH
`define SCSD_DEFS_SVH
// ------------------------------------------------------------
// command block layout
// ------------------------------------------------------------
`define SCSD_CDB_BYTES   4'd10      // bytes in a download command block
`define SCSD_CDB_LAST    4'd9       // index of the final command byte
`define SCSD_OPCODE      8'h2a      // parameter-download operation code
`define SCSD_B_OP        0          // opcode byte
`define SCSD_B_RSV1      1          // reserved byte
`define SCSD_B_TYPE      2          // data type byte
`define SCSD_B_RSV3      3          // reserved byte
`define SCSD_B_TIDH      4          // transfer id, upper byte
`define SCSD_B_TIDL      5          // transfer id, lower byte
`define SCSD_B_RSV6      6          // reserved byte
`define SCSD_B_LENH      7          // transfer length, upper byte
`define SCSD_B_LENL      8          // transfer length, lower byte
`define SCSD_B_RSV9      9          // reserved byte
`define SCSD_ZERO_BYTE   8'h00      // value of every reserved byte
`define SCSD_TID_HI      8'h00      // transfer id upper byte
`define SCSD_TID_LO      8'h02      // transfer id lower byte
// ------------------------------------------------------------
// data types
// ------------------------------------------------------------
`define SCSD_T_CCM       8'h01      // colour correction matrix
`define SCSD_T_HT        8'h02      // halftone page
`define SCSD_T_GAM       8'h03      // gamma table
`define SCSD_T_CAL       8'h80      // pixel calibration ram
// ------------------------------------------------------------
// transfer lengths and halftone dimension codes
// ------------------------------------------------------------
`define SCSD_LEN_HT4     16'd17     // dimension byte plus 4x4 thresholds
`define SCSD_LEN_HT8     16'd65     // dimension byte plus 8x8 thresholds
`define SCSD_LEN_CAL_M   16'd2550   // calibration, monochrome sensor
`define SCSD_LEN_CAL_C   16'd8100   // calibration, three sensor lines
`define SCSD_LEN_CCM     16'd18     // colour correction matrix
`define SCSD_LEN_GAM     16'd768    // gamma table, three colours
`define SCSD_DIM4        8'h44      // 4 rows, 4 columns
`define SCSD_DIM8        8'h88      // 8 rows, 8 columns
`define SCSD_FIFO_DEPTH  16         // words in the data fifo
`endif

//--- inc/scsd_pkg.sv
package scsd_pkg;
   // ------------------------------------------------------------
   // model, target and state types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SCSD_M_BASIC  = 2'h0,          // basic monochrome
      SCSD_M_MONO2  = 2'h1,          // second monochrome
      SCSD_M_COLOUR = 2'h2           // colour model
   } scsd_model_t;

   typedef enum logic [1:0] {
      SCSD_TG_HT    = 2'h0,          // halftone matrix storage
      SCSD_TG_CAL   = 2'h1,          // pixel_calibration_ram
      SCSD_TG_CCM   = 2'h2,          // colour correction matrix
      SCSD_TG_GAM   = 2'h3           // gamma table
   } scsd_target_t;

   typedef enum logic [2:0] {
      SCSD_D_CDB    = 3'h0,          // collecting command bytes
      SCSD_D_CHECK  = 3'h1,          // validating the block
      SCSD_D_DATA   = 3'h3,          // taking parameter bytes
      SCSD_D_STAT   = 3'h2           // reporting status
   } scsd_dev_state_t;

   typedef enum logic [1:0] {
      SCSD_H_IDLE   = 2'h0,          // waiting for start
      SCSD_H_CMD    = 2'h1,          // sending command bytes
      SCSD_H_WAIT   = 2'h3,          // waiting for data request or status
      SCSD_H_DATA   = 2'h2           // sending parameter bytes
   } scsd_host_state_t;
endpackage

//--- inc/scsd_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// byte link between initiator and device
// ------------------------------------------------------------
interface scsd_if;
   logic       b_valid;              // host offers a byte
   logic       b_ready;              // device takes the byte
   logic [7:0] b_data;               // byte value
   logic       b_cdb;                // byte belongs to the command block
   logic       data_req;             // device wants parameter bytes
   logic       stat_valid;           // one-cycle status strobe
   logic       stat_good;            // status is good

   modport dev (input b_valid, b_data, b_cdb, output b_ready, data_req, stat_valid, stat_good);
   modport host (output b_valid, b_data, b_cdb, input b_ready, data_req, stat_valid, stat_good);
endinterface
`default_nettype wire

//--- core/scsd_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsd_defs.svh"

// ------------------------------------------------------------
// data fifo
// ------------------------------------------------------------
module scsd_fifo
   import scsd_pkg::*;
#(
   parameter int W = 8,
   parameter int D = `SCSD_FIFO_DEPTH
)(
   input  wire logic         sys_clk,     // system clock
   input  wire logic         rst,         // synchronous reset
   input  wire logic         in_valid,    // write side offers a word
   output logic              in_ready,    // room for a word
   input  wire logic [W-1:0] in_data,     // word written
   output logic              out_valid,   // a word is held
   input  wire logic         out_ready,   // read side takes the word
   output logic [W-1:0]      out_data     // oldest word
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem_r [D];              // storage
   logic [AW-1:0] wp_r, wp_nxt;           // write pointer
   logic [AW-1:0] rp_r, rp_nxt;           // read pointer
   logic [AW:0]   cnt_r, cnt_nxt;         // words held
   logic          push, pop;              // handshakes

   // pointer and fill arithmetic
   always_comb
   begin
      // full at D words; a narrower cast of D would wrap to zero
      in_ready  = (cnt_r != (AW+1)'(D));
      out_valid = (cnt_r != '0);
      out_data  = mem_r[rp_r];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wp_nxt    = push ? wp_r + 1'b1 : wp_r;
      rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   // pointer registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage write, no reset needed
   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule

// ------------------------------------------------------------
// device end: command check and parameter routing
// ------------------------------------------------------------
module scsd_dev
   import scsd_pkg::*;
#(
   parameter int FIFO_DEPTH = `SCSD_FIFO_DEPTH
)(
   input  wire logic         sys_clk,     // system clock
   input  wire logic         rst,         // synchronous reset
   scsd_if.dev               link,        // link to the initiator
   input  wire scsd_model_t  model,       // which model this device is
   output logic              wr_valid,    // storage write offered
   input  wire logic         wr_ready,    // storage takes the write
   output scsd_target_t      wr_target,   // storage selected
   output logic [15:0]       wr_addr,     // byte index in the page
   output logic [7:0]        wr_data,     // byte written
   output logic              cmd_done,    // command ended, one cycle
   output logic              cmd_good     // status of the ended command
);
   // ------------------------------------------------------------
   // check functions
   // ------------------------------------------------------------
   // true when the block is legal for the model
   function automatic logic cdb_ok(input scsd_model_t m, input logic [9:0][7:0] c);
      logic [15:0] len;
      logic        ok;
      len = {c[`SCSD_B_LENH], c[`SCSD_B_LENL]};
      ok  = (c[`SCSD_B_OP] == `SCSD_OPCODE)
         && (c[`SCSD_B_RSV1] == `SCSD_ZERO_BYTE) && (c[`SCSD_B_RSV3] == `SCSD_ZERO_BYTE)
         && (c[`SCSD_B_RSV6] == `SCSD_ZERO_BYTE) && (c[`SCSD_B_RSV9] == `SCSD_ZERO_BYTE)
         && (c[`SCSD_B_TIDH] == `SCSD_TID_HI)
         && (c[`SCSD_B_TIDL] == `SCSD_TID_LO);
      case (m)
         SCSD_M_BASIC:
            ok = ok && (c[`SCSD_B_TYPE] == `SCSD_T_HT) && (len == `SCSD_LEN_HT4);
         SCSD_M_MONO2:
            ok = ok && (((c[`SCSD_B_TYPE] == `SCSD_T_HT)
                        && ((len == `SCSD_LEN_HT4) || (len == `SCSD_LEN_HT8)))
                     || ((c[`SCSD_B_TYPE] == `SCSD_T_CAL) && (len == `SCSD_LEN_CAL_M)));
         SCSD_M_COLOUR:
            ok = ok && (((c[`SCSD_B_TYPE] == `SCSD_T_CCM) && (len == `SCSD_LEN_CCM))
                     || ((c[`SCSD_B_TYPE] == `SCSD_T_GAM) && (len == `SCSD_LEN_GAM))
                     || ((c[`SCSD_B_TYPE] == `SCSD_T_CAL) && (len == `SCSD_LEN_CAL_C)));
         default:
            ok = 1'b0;                    // unknown model refuses all
      endcase
      return ok;
   endfunction

   // storage chosen by data type
   function automatic scsd_target_t type_target(input logic [7:0] t);
      case (t)
         `SCSD_T_CCM: return SCSD_TG_CCM;
         `SCSD_T_GAM: return SCSD_TG_GAM;
         `SCSD_T_CAL: return SCSD_TG_CAL;
         default:     return SCSD_TG_HT;
      endcase
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   scsd_dev_state_t  st_r, st_nxt;        // controller state
   logic [3:0]       idx_r, idx_nxt;      // command byte index
   logic [9:0][7:0]  cdb_r, cdb_nxt;      // command block store
   logic [15:0]      len_r, len_nxt;      // accepted transfer length
   scsd_target_t     tgt_r, tgt_nxt;      // accepted target
   logic [15:0]      rx_r, rx_nxt;        // bytes taken from the link
   logic [15:0]      wa_r, wa_nxt;        // bytes written to storage
   logic             bad_r, bad_nxt;      // error seen
   logic             f_in_valid;          // fifo write strobe
   logic             f_in_ready;          // fifo has room
   logic             f_out_valid;         // fifo holds a byte
   logic             more;                // link bytes still owed

   // ------------------------------------------------------------
   // data buffer between link and storage
   // ------------------------------------------------------------
   scsd_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (link.b_data),
      .out_valid (f_out_valid),
      .out_ready (wr_ready),
      .out_data  (wr_data)
   );

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt  = st_r;
      idx_nxt = idx_r;
      cdb_nxt = cdb_r;
      len_nxt = len_r;
      tgt_nxt = tgt_r;
      rx_nxt  = rx_r;
      wa_nxt  = wa_r;
      bad_nxt = bad_r;
      more    = (st_r == SCSD_D_DATA) && (rx_r != len_r);
      // only bytes owed are taken; fifo full stalls the link
      f_in_valid      = more && link.b_valid && !link.b_cdb;
      link.b_ready    = ((st_r == SCSD_D_CDB) && link.b_cdb) || (more && !link.b_cdb && f_in_ready);
      link.data_req   = more;
      link.stat_valid = (st_r == SCSD_D_STAT);
      link.stat_good  = !bad_r;
      wr_valid        = f_out_valid;
      case (st_r)
         SCSD_D_CDB:
         begin
            // gather the ten command bytes
            if (link.b_valid && link.b_cdb)
            begin
               cdb_nxt[idx_r] = link.b_data;
               if (idx_r == `SCSD_CDB_LAST)
               begin
                  idx_nxt = 4'h0;
                  st_nxt  = SCSD_D_CHECK;
               end
               else
               begin
                  idx_nxt = idx_r + 4'h1;
               end
            end
         end
         SCSD_D_CHECK:
         begin
            // legal block opens the data phase, else error at once
            len_nxt = {cdb_r[`SCSD_B_LENH], cdb_r[`SCSD_B_LENL]};
            tgt_nxt = type_target(cdb_r[`SCSD_B_TYPE]);
            rx_nxt  = 16'h0000;
            wa_nxt  = 16'h0000;
            if (cdb_ok(model, cdb_r))
            begin
               bad_nxt = 1'b0;
               st_nxt  = SCSD_D_DATA;
            end
            else
            begin
               bad_nxt = 1'b1;
               st_nxt  = SCSD_D_STAT;
            end
         end
         SCSD_D_DATA:
         begin
            if (f_in_valid && f_in_ready)
            begin
               rx_nxt = rx_r + 16'h0001;
            end
            // each byte goes out in arrival order, one address per byte
            if (f_out_valid && wr_ready)
            begin
               wa_nxt = wa_r + 16'h0001;
               // first halftone byte must give the page dimensions
               if ((tgt_r == SCSD_TG_HT) && (wa_r == 16'h0000))
               begin
                  if (wr_data != ((len_r == `SCSD_LEN_HT8) ? `SCSD_DIM8 : `SCSD_DIM4))
                  begin
                     bad_nxt = 1'b1;
                  end
               end
               if (wa_nxt == len_r)
               begin
                  st_nxt = SCSD_D_STAT;
               end
            end
         end
         SCSD_D_STAT:
         begin
            st_nxt = SCSD_D_CDB;              // status shown for one cycle
         end
         default:
         begin
            st_nxt = SCSD_D_CDB;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r  <= SCSD_D_CDB;
         idx_r <= 4'h0;
         cdb_r <= '0;
         len_r <= 16'h0000;
         tgt_r <= SCSD_TG_HT;
         rx_r  <= 16'h0000;
         wa_r  <= 16'h0000;
         bad_r <= 1'b0;
      end
      else
      begin
         st_r  <= st_nxt;
         idx_r <= idx_nxt;
         cdb_r <= cdb_nxt;
         len_r <= len_nxt;
         tgt_r <= tgt_nxt;
         rx_r  <= rx_nxt;
         wa_r  <= wa_nxt;
         bad_r <= bad_nxt;
      end
   end

   // ------------------------------------------------------------
   // user-side outputs
   // ------------------------------------------------------------
   assign wr_target = tgt_r;
   assign wr_addr   = wa_r;
   assign cmd_done  = (st_r == SCSD_D_STAT);
   assign cmd_good  = !bad_r;
endmodule
`default_nettype wire

//--- core/scsd_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsd_defs.svh"

// ------------------------------------------------------------
// initiator end: builds and sends the download command
// ------------------------------------------------------------
module scsd_host
   import scsd_pkg::*;
(
   input  wire logic         sys_clk,     // system clock
   input  wire logic         rst,         // synchronous reset
   scsd_if.host              link,        // link to the device
   input  wire logic         start,       // begin a download, one cycle
   input  wire scsd_model_t  model,       // model of the device
   input  wire logic [7:0]   xfer_type,   // data type to send
   input  wire logic         ht_large,    // halftone page is 8x8
   input  wire logic         usr_valid,   // user offers a data byte
   input  wire logic [7:0]   usr_data,    // data byte
   output logic              usr_ready,   // data byte taken
   output logic              busy,        // command in progress
   output logic              done,        // status received, one cycle
   output logic              good         // last status was good
);
   // length that belongs to the model and data type
   function automatic logic [15:0] len_for(input scsd_model_t m, input logic [7:0] t, input logic big);
      case (t)
         `SCSD_T_CCM: return `SCSD_LEN_CCM;
         `SCSD_T_GAM: return `SCSD_LEN_GAM;
         `SCSD_T_CAL: return (m == SCSD_M_COLOUR) ? `SCSD_LEN_CAL_C : `SCSD_LEN_CAL_M;
         default:     return (big && (m != SCSD_M_BASIC)) ? `SCSD_LEN_HT8 : `SCSD_LEN_HT4;
      endcase
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   scsd_host_state_t st_r, st_nxt;        // controller state
   logic [3:0]       idx_r, idx_nxt;      // command byte index
   logic [9:0][7:0]  cdb_r, cdb_nxt;      // command block to send
   logic             done_r, done_nxt;    // status strobe
   logic             good_r, good_nxt;    // status value

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt    = st_r;
      idx_nxt   = idx_r;
      cdb_nxt   = cdb_r;
      done_nxt  = 1'b0;
      good_nxt  = good_r;
      link.b_valid = 1'b0;
      link.b_cdb   = 1'b0;
      link.b_data  = cdb_r[idx_r];
      usr_ready    = 1'b0;
      case (st_r)
         SCSD_H_IDLE:
         begin
            // reserved bytes zero, id 00 02 for every model
            if (start)
            begin
               cdb_nxt                = '0;
               cdb_nxt[`SCSD_B_OP]    = `SCSD_OPCODE;
               cdb_nxt[`SCSD_B_TYPE]  = (model == SCSD_M_BASIC) ? `SCSD_T_HT : xfer_type;
               cdb_nxt[`SCSD_B_TIDH]  = `SCSD_TID_HI;
               cdb_nxt[`SCSD_B_TIDL]  = `SCSD_TID_LO;
               {cdb_nxt[`SCSD_B_LENH], cdb_nxt[`SCSD_B_LENL]} = len_for(model, cdb_nxt[`SCSD_B_TYPE], ht_large);
               idx_nxt = 4'h0;
               st_nxt  = SCSD_H_CMD;
            end
         end
         SCSD_H_CMD:
         begin
            // command bytes in order 0 to 9
            link.b_valid = 1'b1;
            link.b_cdb   = 1'b1;
            if (link.b_ready)
            begin
               if (idx_r == `SCSD_CDB_LAST)
               begin
                  idx_nxt = 4'h0;
                  st_nxt  = SCSD_H_WAIT;
               end
               else
               begin
                  idx_nxt = idx_r + 4'h1;
               end
            end
         end
         SCSD_H_WAIT, SCSD_H_DATA:
         begin
            // user bytes pass while the device asks for them
            if (link.data_req)
            begin
               st_nxt       = SCSD_H_DATA;
               link.b_valid = usr_valid;
               link.b_data  = usr_data;
               usr_ready    = link.b_ready;
            end
            if (link.stat_valid)
            begin
               done_nxt = 1'b1;
               good_nxt = link.stat_good;
               st_nxt   = SCSD_H_IDLE;
            end
         end
         default:
         begin
            st_nxt = SCSD_H_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r   <= SCSD_H_IDLE;
         idx_r  <= 4'h0;
         cdb_r  <= '0;
         done_r <= 1'b0;
         good_r <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         idx_r  <= idx_nxt;
         cdb_r  <= cdb_nxt;
         done_r <= done_nxt;
         good_r <= good_nxt;
      end
   end

   assign busy = (st_r != SCSD_H_IDLE);
   assign done = done_r;
   assign good = good_r;
endmodule
`default_nettype wire

//--- testbench/scsd_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// link checks
// ----
module scsd_checker (
   input wire logic       sys_clk,    // clock
   input wire logic       rst,        // reset
   input wire logic       b_valid,    // byte offered
   input wire logic       b_ready,    // byte taken
   input wire logic [7:0] b_data,     // byte value
   input wire logic       b_cdb,      // command byte
   input wire logic       data_req,   // bytes owed
   input wire logic       stat_valid, // status strobe
   input wire logic       stat_good   // status good
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // one command byte taken
   sequence s_tk;
      b_valid && b_ready && b_cdb;
   endsequence
   // ten command bytes back to back
   sequence s_cdb;
      s_tk [*8] ##1 s_tk [*2];
   endsequence
   a_stat_pulse: assert property (stat_valid |=> !stat_valid)
      else $error("status strobe too long");
   a_stat_no_req: assert property (stat_valid |-> !data_req)
      else $error("status while bytes owed");
   a_data_gated: assert property (b_ready && !b_cdb |-> data_req)
      else $error("data byte taken unasked");
   a_cdb_taken: assert property (b_valid && b_cdb && !data_req && !stat_valid |-> b_ready)
      else $error("command byte refused");
   a_cdb_answer: assert property (s_cdb |-> ##2 (stat_valid ^ data_req))
      else $error("no answer after command");
   a_cdb_refuse: assert property (s_cdb ##2 stat_valid |-> !stat_good)
      else $error("good status without data");
   a_req_cause: assert property ($rose(data_req) |-> $past(b_valid && b_cdb && b_ready, 2))
      else $error("data request without command");
   a_end_good: assert property ($fell(data_req) |-> ##[1:100] (stat_valid && stat_good))
      else $error("no good status after data");
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// download bench
// ----
module testbench;
   import scsd_pkg::*;
   logic         sys_clk, rst = 1'b1, start = 1'b0, ht_large = 1'b0, usr_valid = 1'b0; // host inputs
   logic         usr_ready, busy, done, good, wr_valid, wr_ready = 1'b0, cmd_done, cmd_good; // flags
   logic [7:0]   xfer_type = 8'h00, usr_data = 8'h00, wr_data; // type and data
   logic [15:0]  wr_addr;                    // stored byte index
   scsd_model_t  model = SCSD_M_BASIC, model2 = SCSD_M_BASIC; // device models
   scsd_target_t wr_target, tgt_e;           // storage seen, expected
   logic         ht_e, lg_e;                 // halftone page, 8x8 page
   int           mismatches = 0, cmp_count = 0, wcnt = 0, hold = 0, cyc = 0; // counters
   scsd_if link ();
   scsd_if link2 ();
   scsd_host scsd_host_i (.sys_clk, .rst, .link, .start, .model, .xfer_type, .ht_large, .usr_valid,
      .usr_data, .usr_ready, .busy, .done, .good);
   scsd_dev scsd_dev_i (.sys_clk, .rst, .link, .model, .wr_valid, .wr_ready, .wr_target, .wr_addr,
      .wr_data, .cmd_done, .cmd_good);
   scsd_dev scsd_dev_f_i (.sys_clk, .rst, .link(link2), .model(model2), .wr_valid(), .wr_ready(1'b1),
      .wr_target(), .wr_addr(), .wr_data(), .cmd_done(), .cmd_good());
   scsd_checker scsd_checker_i (.sys_clk, .rst, .b_valid(link.b_valid), .b_ready(link.b_ready),
      .b_data(link.b_data), .b_cdb(link.b_cdb), .data_req(link.data_req),
      .stat_valid(link.stat_valid), .stat_good(link.stat_good));
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // byte k of a page: dimension code first on halftone
   function automatic logic [7:0] pat(input int k);
      return (ht_e && k == 0) ? (lg_e ? 8'h88 : 8'h44) : k[7:0];
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (e !== s)
      begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // sink stalls one cycle in eight, and wholly while hold runs
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      hold <= (hold > 0) ? hold - 1 : 0;
      wr_ready <= hold == 0 && cyc % 8 != 7;
   end
   // every storage write compared when taken
   always @(negedge sys_clk)
      if (!rst && wr_valid === 1'b1 && wr_ready)
      begin
         chk("wr_addr", wcnt, {16'h0, wr_addr});
         chk("wr_data", {24'h0, pat(wcnt)}, {24'h0, wr_data});
         chk("wr_target", tgt_e, wr_target);
         wcnt++;
      end
   // one download through the host, refused when eg is low
   task automatic dl(input scsd_model_t m, input logic [7:0] t, input logic lg, input scsd_target_t tg,
      input int len, input logic eg);
      int k;
      logic tk, got;
      k = 0;
      got = 1'b0;
      wcnt = 0;
      ht_e = t == 8'h02;
      lg_e = lg;
      tgt_e = tg;
      @(posedge sys_clk);
      model <= m;
      xfer_type <= t;
      ht_large <= lg;
      start <= 1'b1;
      usr_valid <= 1'b1;
      usr_data <= pat(0);
      @(posedge sys_clk);
      start <= 1'b0;
      for (int n = 0; n < 30000 && !got; n++)
      begin
         @(negedge sys_clk);
         got = done === 1'b1;
         tk = usr_ready === 1'b1;
         chk("busy", !got, busy);
         if (cmd_done === 1'b1)
            chk("cmd_good", eg, cmd_good);
         if (n == 40 && hold > 0)
            chk("fifo_full", 1, k <= 17 && usr_ready === 1'b0);
         @(posedge sys_clk);
         if (tk && k < len)
         begin
            k++;
            usr_data <= pat(k);
            usr_valid <= k < len;
         end
      end
      usr_valid <= 1'b0;
      chk("good", eg, good);
      chk("sent", eg ? len : 0, k);
      chk("written", eg ? len : 0, wcnt);
   endtask
   // faulty command block straight onto the second device
   task automatic raw(input scsd_model_t m, input logic [79:0] c);
      logic seen, req;
      seen = 1'b0;
      req = 1'b0;
      @(posedge sys_clk);
      model2 <= m;
      link2.b_valid <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         link2.b_data <= c[79 - 8 * i -: 8];
         @(posedge sys_clk);
      end
      link2.b_valid <= 1'b0;
      repeat (4)
      begin
         @(negedge sys_clk);
         seen |= link2.stat_valid === 1'b1 && link2.stat_good === 1'b0;
         req |= link2.data_req !== 1'b0;
      end
      chk("refused", 2, {seen, req});
   endtask
   initial
   begin
      link2.b_valid = 1'b0;
      link2.b_cdb = 1'b1;
      link2.b_data = 8'h00;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      dl(SCSD_M_BASIC, 8'h02, 1'b0, SCSD_TG_HT, 17, 1'b1);
      dl(SCSD_M_MONO2, 8'h02, 1'b0, SCSD_TG_HT, 17, 1'b1);
      dl(SCSD_M_MONO2, 8'h02, 1'b1, SCSD_TG_HT, 65, 1'b1);
      @(negedge sys_clk) hold = 60;
      dl(SCSD_M_MONO2, 8'h80, 1'b0, SCSD_TG_CAL, 2550, 1'b1);
      dl(SCSD_M_COLOUR, 8'h01, 1'b0, SCSD_TG_CCM, 18, 1'b1);
      dl(SCSD_M_COLOUR, 8'h03, 1'b0, SCSD_TG_GAM, 768, 1'b1);
      dl(SCSD_M_COLOUR, 8'h80, 1'b0, SCSD_TG_CAL, 8100, 1'b1);
      dl(SCSD_M_COLOUR, 8'h02, 1'b0, SCSD_TG_HT, 0, 1'b0);
      dl(SCSD_M_MONO2, 8'h01, 1'b0, SCSD_TG_CCM, 0, 1'b0);
      raw(SCSD_M_BASIC, 80'h28_00_02_00_00_02_00_00_11_00);
      raw(SCSD_M_BASIC, 80'h2a_01_02_00_00_02_00_00_11_00);
      raw(SCSD_M_BASIC, 80'h2a_00_02_00_00_03_00_00_11_00);
      raw(SCSD_M_BASIC, 80'h2a_00_02_00_00_02_00_00_12_00);
      raw(SCSD_M_MONO2, 80'h2a_00_02_00_01_02_00_00_11_00);
      raw(SCSD_M_MONO2, 80'h2a_00_02_00_00_02_00_00_12_00);
      raw(SCSD_M_COLOUR, 80'h2a_00_01_00_00_02_00_00_13_00);
      give_verdict();
   end
   // watchdog
   initial
   begin
      #400000;
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
